// ===== hw/frg_guard.v
// Flash rewrite guard: window, security, boot swap and data flash access gating
`timescale 1ns/100ps
`default_nettype none
`include "frg_map.vh"
module frg_guard #(
    parameter AW = 20,
    parameter BW = 8,
    parameter CNTW = 8
)
(
    input wire clk,
    input wire rst,
    input wire sys_on_subclk,
    input wire low_speed_main_mode,
    input wire nv_erase_prot,
    input wire nv_write_prot,
    input wire nv_boot0_prot,
    input wire nv_swap,
    input wire [BW-1:0] nv_win_start,
    input wire [BW-1:0] nv_win_end,
    input wire flash_blank,
    input wire req_valid,
    input wire req_serial,
    input wire [1:0] req_op,
    input wire req_data_flash,
    input wire [BW-1:0] req_block,
    input wire [AW-1:0] req_addr,
    input wire sec_valid,
    input wire sec_serial,
    input wire sec_set_erase,
    input wire sec_set_write,
    input wire sec_set_boot0,
    input wire sec_release_write,
    input wire sec_set_swap,
    input wire win_valid,
    input wire [BW-1:0] win_start,
    input wire [BW-1:0] win_end,
    input wire reg_wr,
    input wire reg_bit_wr,
    input wire [AW-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    input wire df_acc_valid,
    input wire df_acc_fetch,
    input wire df_acc_byte,
    input wire df_rewrite_busy,
    input wire cf_rewrite_busy,
    input wire stop_req,
    output reg [7:0] reg_rdata_q,
    output reg grant_q,
    output reg error_q,
    output reg nv_upd_q,
    output reg nv_erase_prot_q,
    output reg nv_write_prot_q,
    output reg nv_boot0_prot_q,
    output reg nv_swap_q,
    output reg [BW-1:0] nv_win_start_q,
    output reg [BW-1:0] nv_win_end_q,
    output reg sec_err_q,
    output reg boot_from_c1_q,
    output reg df_grant_q,
    output reg df_err_q,
    output reg stop_ok_q
);
    // Effective settings; prohibits captured after reset release
    reg erase_p_q;
    reg write_p_q;
    reg boot0_p_q;
    reg [BW-1:0] ws_q;
    reg [BW-1:0] we_q;
    reg load_q;
    reg df_en_q;
    wire df_ready;
    wire self_bad;
    wire in_boot0;
    wire in_win;
    wire ok;
    wire dfc_wr;
    wire en_rise;
    wire [CNTW-1:0] setup_cyc;

    // Cluster 0 address span; swap maps cluster 1 in, unprotecting physical cluster 0
    assign in_boot0 = !req_data_flash && (req_addr <= `FRG_BOOT_HI) && !boot_from_c1_q;
    assign in_win = (req_block >= ws_q) && (req_block <= we_q);
    assign self_bad = !req_serial && sys_on_subclk;
    assign ok = !self_bad
        && !(boot0_p_q && in_boot0)
        && (req_serial || req_data_flash || in_win)
        && !(req_serial && erase_p_q && req_op == `FRG_OP_ERASE)
        && !(req_serial && write_p_q && !req_data_flash && req_op == `FRG_OP_WRITE)
        && !(req_data_flash && cf_rewrite_busy);
    assign dfc_wr = reg_wr && (reg_addr == `FRG_DFC_ADDR) && !df_rewrite_busy;
    // Bit and byte writes land alike: the enable is the only stored bit, so a bit write carries it in bit 0
    assign en_rise = dfc_wr && (reg_bit_wr ? 1'b1 : 1'b1) && reg_wdata[`FRG_DFC_EN_BIT] && !df_en_q;

    // Setup counts come out of 32-bit constant arithmetic; only the counter's own bits are kept.
    // Limitation: CNTW must hold the high speed count, otherwise the wait would be cut short.
    localparam [31:0] SETUP_SLOW_W = `FRG_SETUP_SLOW_CYC;
    localparam [31:0] SETUP_FAST_W = `FRG_SETUP_FAST_CYC;
    // Mode level picks the wait; counts are rounded up so the wait is never shorter than asked
    assign setup_cyc = low_speed_main_mode ? SETUP_SLOW_W[CNTW-1:0] : SETUP_FAST_W[CNTW-1:0];

    // The timer is held clear while access is off, so a later enable always waits the full time

    frg_setup_timer #(
        .CW(CNTW)
    ) u_setup (
        .clk(clk),
        .rst(rst),
        .start(en_rise),
        .clear(!df_en_q && !en_rise),
        .load(setup_cyc),
        .ready_q(df_ready)
    );

    // Non-volatile settings are latched once after reset; set commands and window writes then update them, swap stays fixed until the next reset
    always @(posedge clk)
    begin
        if (rst)
        begin
            load_q <= 1'b1;
            erase_p_q <= 1'b0;
            write_p_q <= 1'b0;
            boot0_p_q <= 1'b0;
            ws_q <= {BW{1'b0}};
            we_q <= {BW{1'b1}};
            boot_from_c1_q <= 1'b0;
        end
        else if (load_q)
        begin
            load_q <= 1'b0;
            erase_p_q <= nv_erase_prot;
            write_p_q <= nv_write_prot;
            boot0_p_q <= nv_boot0_prot;
            ws_q <= nv_win_start;
            we_q <= nv_win_end;
            boot_from_c1_q <= nv_swap;
        end
        else
        begin
            if (sec_valid && sec_set_erase)
                erase_p_q <= 1'b1;
            if (sec_valid && sec_set_write)
                write_p_q <= 1'b1;
            if (sec_valid && sec_set_boot0)
                boot0_p_q <= 1'b1;
            if (win_valid)
            begin
                ws_q <= win_start;
                we_q <= win_end;
            end
        end
    end

    // Outgoing non-volatile image; release only written to storage, not to live state
    always @(posedge clk)
    begin
        if (rst)
        begin
            nv_upd_q <= 1'b0;
            nv_erase_prot_q <= 1'b0;
            nv_write_prot_q <= 1'b0;
            nv_boot0_prot_q <= 1'b0;
            nv_swap_q <= 1'b0;
            nv_win_start_q <= {BW{1'b0}};
            nv_win_end_q <= {BW{1'b1}};
            sec_err_q <= 1'b0;
        end
        else
        begin
            nv_upd_q <= sec_valid || win_valid;
            sec_err_q <= 1'b0;
            if (load_q)
            begin
                nv_erase_prot_q <= nv_erase_prot;
                nv_write_prot_q <= nv_write_prot;
                nv_boot0_prot_q <= nv_boot0_prot;
                nv_swap_q <= nv_swap;
                nv_win_start_q <= nv_win_start;
                nv_win_end_q <= nv_win_end;
            end
            else
            begin
                if (sec_valid && sec_set_erase)
                    nv_erase_prot_q <= 1'b1;
                if (sec_valid && sec_set_boot0)
                    nv_boot0_prot_q <= 1'b1;
                if (sec_valid && sec_set_swap)
                    nv_swap_q <= ~nv_swap_q;
                if (sec_valid && sec_set_write)
                    nv_write_prot_q <= 1'b1;
                else if (sec_valid && sec_release_write)
                begin
                    // Release refused from self-programming or when preconditions fail
                    if (sec_serial && !erase_p_q && !boot0_p_q && flash_blank)
                        nv_write_prot_q <= 1'b0;
                    else
                        sec_err_q <= 1'b1;
                end
                if (win_valid)
                begin
                    nv_win_start_q <= win_start;
                    nv_win_end_q <= win_end;
                end
            end
        end
    end

    // Rewrite request verdict, one cycle after the request
    always @(posedge clk)
    begin
        if (rst)
        begin
            grant_q <= 1'b0;
            error_q <= 1'b0;
        end
        else
        begin
            grant_q <= req_valid && !load_q && ok;
            error_q <= req_valid && (load_q || !ok);
        end
    end

    // Data flash control register and byte access gating
    always @(posedge clk)
    begin
        if (rst)
        begin
            df_en_q <= 1'b0;
            reg_rdata_q <= `FRG_DFC_RESET;
            df_grant_q <= 1'b0;
            df_err_q <= 1'b0;
            stop_ok_q <= 1'b1;
        end
        else
        begin
            // A write during a data flash rewrite is dropped, not deferred
            if (dfc_wr)
                df_en_q <= reg_wdata[`FRG_DFC_EN_BIT];
            // Unused bits read zero; other addresses read zero as well
            if (reg_rd && reg_addr == `FRG_DFC_ADDR)
                reg_rdata_q <= {7'h00, df_en_q};
            else
                reg_rdata_q <= 8'h00;
            // Fetches never hit data flash; code flash keeps serving them independently
            df_grant_q <= df_acc_valid && df_en_q && df_ready && df_acc_byte && !df_acc_fetch
                && !cf_rewrite_busy;
            df_err_q <= df_acc_valid && !(df_en_q && df_ready && df_acc_byte && !df_acc_fetch && !cf_rewrite_busy);
            // Stop blocked during rewrite and during the setup wait
            stop_ok_q <= !df_rewrite_busy && !(df_en_q && !df_ready) && !stop_req;
        end
    end
endmodule // frg_guard
`default_nettype wire

// ===== hw/frg_map.vh
// Offsets, field positions, reset values and timing counts of the flash rewrite guard
`ifndef FRG_MAP_VH
`define FRG_MAP_VH
`define FRG_DFC_ADDR 20'hf0090
`define FRG_DFC_RESET 8'h00
`define FRG_DFC_EN_BIT 0
`define FRG_BOOT_LO 20'h00000
`define FRG_BOOT_HI 20'h00fff
`define FRG_CLUSTER_BYTES 20'h01000
`define FRG_DF_BLOCK_BYTES 20'h00400
`define FRG_CLK_MHZ 40
`define FRG_SETUP_FAST_NS 5000
`define FRG_SETUP_SLOW_NS 720
`define FRG_SETUP_FAST_CYC ((`FRG_SETUP_FAST_NS * `FRG_CLK_MHZ + 999) / 1000)
`define FRG_SETUP_SLOW_CYC ((`FRG_SETUP_SLOW_NS * `FRG_CLK_MHZ + 999) / 1000)
`define FRG_OP_ERASE 2'h1
`define FRG_OP_WRITE 2'h2
`endif

// ===== hw/frg_setup_timer.v
// Data flash setup delay counter
`timescale 1ns/100ps
`default_nettype none
module frg_setup_timer #(
    parameter CW = 8
)
(
    input wire clk,
    input wire rst,
    input wire start,
    input wire clear,
    input wire [CW-1:0] load,
    output reg ready_q
);
    reg [CW-1:0] cnt_q;

    // Counts down after enable; ready only once the full delay elapsed
    always @(posedge clk)
    begin
        if (rst || clear)
        begin
            cnt_q <= {CW{1'b0}};
            ready_q <= 1'b0;
        end
        else if (start)
        begin
            cnt_q <= load;
            ready_q <= 1'b0;
        end
        else if (cnt_q > {{(CW-1){1'b0}}, 1'b1})
            cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
        else if (cnt_q != {CW{1'b0}})
        begin
            cnt_q <= {CW{1'b0}};
            ready_q <= 1'b1;
        end
    end
endmodule // frg_setup_timer
`default_nettype wire

// ===== verification/frg_req_model.sv
// Requester model standing for the flash library or a serial programmer
`timescale 1ns/100ps
`default_nettype none
module frg_req_model (
    input wire logic clk,
    output logic req_valid, req_serial, req_data_flash,
    output logic [1:0] req_op,
    output logic [7:0] req_block,
    output logic [19:0] req_addr
);
    initial {req_valid, req_serial, req_op, req_data_flash, req_block, req_addr} = '0;
    // One-cycle request; fields stay put so the guard never sees a half-changed request
    task automatic issue(input logic [31:0] f);
        @(negedge clk);
        {req_serial, req_op, req_data_flash, req_block, req_addr, req_valid} = {f, 1'b1};
        @(negedge clk);
        req_valid = 1'b0;
        // Returns while the verdict of the sampling edge still stands
    endtask
endmodule // frg_req_model
`default_nettype wire

// ===== verification/frg_guard_asserts.sv
// Port-level assertions for the flash rewrite guard
`timescale 1ns/100ps
`default_nettype none
module frg_guard_asserts (
    input wire clk, rst, sys_on_subclk, req_valid, req_serial, req_data_flash, reg_rd, df_acc_valid,
    input wire df_acc_fetch, df_acc_byte, cf_rewrite_busy, grant_q, error_q, nv_erase_prot_q,
    input wire nv_boot0_prot_q, boot_from_c1_q, df_grant_q, df_err_q,
    input wire [1:0] req_op,
    input wire [7:0] req_block, nv_win_start_q, nv_win_end_q, reg_rdata_q,
    input wire [19:0] req_addr, reg_addr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_SUBCLK: assert property (req_valid && !req_serial && sys_on_subclk |=> error_q)
        else $error("subclk request granted");
    AST_WINDOW: assert property (req_valid && !req_serial && !req_data_flash &&
        (req_block < nv_win_start_q || req_block > nv_win_end_q) |=> error_q && !grant_q)
        else $error("request outside window granted");
    AST_BOOT0: assert property (req_valid && !req_data_flash && nv_boot0_prot_q &&
        !boot_from_c1_q && req_addr <= 20'h00fff |=> error_q) else $error("boot cluster rewrite granted");
    AST_ERASE: assert property (req_valid && req_serial && req_op == 2'h1 &&
        !req_data_flash && nv_erase_prot_q |=> error_q) else $error("serial erase granted");
    AST_STICKY: assert property (nv_erase_prot_q |=> nv_erase_prot_q)
        else $error("erase protection cleared");
    AST_VERDICT: assert property (req_valid |=> grant_q != error_q)
        else $error("no single verdict");
    AST_RDATA: assert property (reg_rd && reg_addr == 20'hf0090 |=> reg_rdata_q[7:1] == 7'h00)
        else $error("unused control bits read nonzero");
    AST_DFREF: assert property (df_acc_valid && (df_acc_fetch || !df_acc_byte ||
        cf_rewrite_busy) |=> df_err_q && !df_grant_q) else $error("data flash access granted");
endmodule // frg_guard_asserts
bind frg_guard frg_guard_asserts chk_i (.*);
`default_nettype wire

// ===== verification/tb_top.sv
// Directed bench for the flash rewrite guard
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk = 0, rst = 1, sys_on_subclk = 0, low_speed_main_mode = 1, flash_blank = 1, stop_req = 0;
    logic nv_erase_prot = 0, nv_write_prot = 0, nv_boot0_prot = 0, nv_swap = 0, sec_valid = 0, sec_serial = 0;
    logic sec_set_erase = 0, sec_set_write = 0, sec_set_boot0 = 0, sec_release_write = 0, sec_set_swap = 0;
    logic win_valid = 0, reg_wr = 0, reg_bit_wr = 0, reg_rd = 0, df_acc_valid = 0, df_acc_fetch = 0;
    logic df_acc_byte = 1, df_rewrite_busy = 0, cf_rewrite_busy = 0;
    logic [7:0] nv_win_start = 8'h04, nv_win_end = 8'h06, win_start = 8'h00, win_end = 8'h06, reg_wdata = 8'h00;
    logic [19:0] reg_addr = 20'hf0090;
    wire req_valid, req_serial, req_data_flash, grant_q, error_q, nv_upd_q, nv_erase_prot_q, nv_write_prot_q;
    wire nv_boot0_prot_q, nv_swap_q, sec_err_q, boot_from_c1_q, df_grant_q, df_err_q, stop_ok_q;
    wire [1:0] req_op;
    wire [7:0] req_block, reg_rdata_q, nv_win_start_q, nv_win_end_q;
    wire [19:0] req_addr;
    int error_cnt = 0, checks = 0, cyc = 0;
    frg_guard dut (.*);
    frg_req_model req (.*);
    always #12.5 clk = ~clk;
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // Drop every pulse; the one-cycle answer of the edge just passed stands until the next edge
    task automatic fin;
        @(negedge clk);
        {sec_valid, win_valid, reg_wr, reg_rd, df_acc_valid} = '0;
    endtask
    task automatic rq(input string n, input logic [31:0] f, input logic [1:0] e);
        req.issue(f);
        chk(n, {grant_q, error_q}, e);
    endtask
    task automatic sc(input logic s, input logic [4:0] f, input logic e);
        @(negedge clk);
        {sec_serial, sec_set_erase, sec_set_write, sec_set_boot0, sec_release_write, sec_set_swap} = {s, f};
        sec_valid = 1;
        fin;
        chk("sec", sec_err_q, e);
        chk("upd", nv_upd_q, 8'h01);
    endtask
    task automatic wr(input logic [7:0] d);
        @(negedge clk);
        reg_wdata = d;
        reg_wr = 1;
        fin;
    endtask
    task automatic rd(input logic [7:0] e);
        @(negedge clk);
        reg_rd = 1;
        fin;
        chk("reg", reg_rdata_q, e);
    endtask
    task automatic da(input logic [1:0] e);
        @(negedge clk);
        df_acc_valid = 1;
        fin;
        chk("df", {df_grant_q, df_err_q}, e);
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            results;
        end
    end
    initial
    begin
        repeat (8) @(negedge clk);
        rst = 0;
        rd(8'h00);
        reg_addr = 20'hf0091;
        rd(8'h00);
        reg_addr = 20'hf0090;
        rq("in", {4'h4, 8'h04, 20'h01000}, 2'b10);
        rq("out", {4'h2, 8'h07, 20'h01c00}, 2'b01);
        rq("serial", {4'ha, 8'h07, 20'h01c00}, 2'b10);
        rq("dflash", {4'h5, 8'h09, 20'hf1000}, 2'b10);
        sys_on_subclk = 1;
        rq("subclk", {4'h4, 8'h05, 20'h01400}, 2'b01);
        sys_on_subclk = 0;
        $display("window test done");
        sc(1'b0, 5'b10101, 1'b0);
        chk("image", {nv_erase_prot_q, nv_boot0_prot_q, nv_swap_q}, 8'h07);
        rq("ser erase", {4'ha, 8'h05, 20'h01400}, 2'b01);
        rq("self erase", {4'h2, 8'h05, 20'h01400}, 2'b10);
        @(negedge clk);
        win_valid = 1;
        fin;
        chk("win start", nv_win_start_q, 8'h00);
        chk("win end", nv_win_end_q, 8'h06);
        rq("boot0", {4'h4, 8'h03, 20'h00ffc}, 2'b01);
        rq("above", {4'h4, 8'h04, 20'h01000}, 2'b10);
        sc(1'b1, 5'b00010, 1'b1);
        chk("sticky", nv_erase_prot_q, 8'h01);
        sc(1'b1, 5'b01000, 1'b0);
        chk("wprot", nv_write_prot_q, 8'h01);
        rq("ser write", {4'hc, 8'h05, 20'h01400}, 2'b01);
        rq("self write", {4'h4, 8'h05, 20'h01400}, 2'b10);
        sc(1'b0, 5'b00010, 1'b1);
        chk("wprot kept", nv_write_prot_q, 8'h01);
        $display("security test done");
        wr(8'hff);
        rd(8'h01);
        da(2'b01);
        repeat (40) @(negedge clk);
        da(2'b10);
        df_acc_fetch = 1;
        da(2'b01);
        df_acc_fetch = 0;
        df_acc_byte = 0;
        da(2'b01);
        df_acc_byte = 1;
        cf_rewrite_busy = 1;
        da(2'b01);
        cf_rewrite_busy = 0;
        df_rewrite_busy = 1;
        wr(8'h00);
        rd(8'h01);
        chk("stop", stop_ok_q, 8'h00);
        $display("data flash test done");
        // Second reset: stored image holds write prohibit and swap; software now in high speed main mode
        df_rewrite_busy = 0;
        nv_write_prot = 1;
        nv_swap = 1;
        nv_win_start = 8'h00;
        low_speed_main_mode = 0;
        rst = 1;
        repeat (2) @(negedge clk);
        rst = 0;
        rq("ser write", {4'hc, 8'h05, 20'h01400}, 2'b01);
        chk("swap", boot_from_c1_q, 8'h01);
        sc(1'b1, 5'b00010, 1'b0);
        chk("release", nv_write_prot_q, 8'h00);
        rq("held", {4'hc, 8'h05, 20'h01400}, 2'b01);
        sc(1'b0, 5'b00100, 1'b0);
        rq("swapped", {4'h4, 8'h03, 20'h00ffc}, 2'b10);
        rd(8'h00);
        wr(8'h01);
        // Sampling edges 199 and 201 after the enable edge bracket the 200-cycle wait
        repeat (197) @(negedge clk);
        chk("stop wait", stop_ok_q, 8'h00);
        da(2'b01);
        da(2'b10);
        chk("stop free", stop_ok_q, 8'h01);
        $display("reset test done");
        results;
    end
endmodule // tb_top
`default_nettype wire
